// [verilog/scwd_pkg.sv]
// Purpose: Shared constants and types for the serial command word decoder
// Assumes: 29-bit command words, four channels, 22 data bits
// Notes: Bus offsets are byte addresses on a 32-bit Avalon-MM slave
package scwd_pkg;
    // Command word layout
    localparam int CMD_W = 29;
    localparam int DATA_W = 22;
    localparam int NCH = 4;
    localparam int RW_BIT = 28;
    localparam int CH_HI = 27;
    localparam int CH_LO = 24;
    localparam int RS_HI = 23;
    localparam int RS_LO = 22;
    localparam logic [5:0] CMD_BITS = 6'h1d;
    localparam logic [5:0] CNT_MAX = 6'h3f;

    // Register-set codes
    localparam logic [1:0] RS_CTRL = 2'h0;
    localparam logic [1:0] RS_GAIN = 2'h1;
    localparam logic [1:0] RS_OFFS = 2'h2;
    localparam logic [1:0] RS_DATA = 2'h3;
    localparam logic [21:0] DATA_ONES = 22'h3f_ffff;
    localparam logic [21:0] DATA_ZERO = 22'h00_0000;

    // Avalon-MM register map and reset values
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam logic [3:0] OFF_SYSCFG = 4'h8;
    localparam logic [3:0] OFF_LASTCMD = 4'hc;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [21:0] SYSCFG_RST = 22'h00_0000;
    localparam logic [21:0] BANK_RST = 22'h00_0000;
    localparam int STAT_FRAME_BIT = 4;

    // Serial pins from the host controller
    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic sdi;
    } scwd_link_t;

    // Register write request to the channels
    typedef struct packed {
        logic [3:0] ch;
        logic [1:0] rs;
        logic [21:0] data;
    } scwd_wr_t;

    typedef enum logic [3:0] {
        CLS_NONE, CLS_SYS_WR, CLS_CH_WR, CLS_NOP, CLS_RD, CLS_RSVD, CLS_LEN_ERR, CLS_OFF
    } scwd_cls_t;

    typedef enum logic {
        ST_IDLE, ST_FRAME
    } scwd_state_t;
endpackage

// [verilog/scwd_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for the serial pins
// Assumes: Inputs are asynchronous to ref_clk
// Notes: A change is accepted once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module scwd_sync (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire scwd_pkg::scwd_link_t d,
    output scwd_pkg::scwd_link_t q
);
    import scwd_pkg::*;

    logic [2:0] s1_ff, s2_ff, s3_ff, q_ff;
    logic [2:0] din;
    logic [2:0] nxt_q;

    assign din = d;
    assign q = q_ff;

    // Per-pin filter: hold the last agreed level
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_pin
            assign nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
        end
    endgenerate

    // Stage registers; idle pins read high
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_ff <= 3'h7;
            s2_ff <= 3'h7;
            s3_ff <= 3'h7;
            q_ff <= 3'h7;
        end else if (ce) begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end
endmodule
`default_nettype wire

// [verilog/scwd_decoder.sv]
// Purpose: Serial command word decoder with register bank and readback
// Assumes: Serial pins sampled by ref_clk; Avalon-MM slave for control
// Notes: Command is decoded when sync_n rises after exactly 29 bits
// How it works
// - Top bit set starts readback, never write
// - Bits 27..24 select channels three..zero
// - Multi-channel write applies same set and data
// - Zero channels, set 00 loads system config
// - No-operation code changes no config or bank register, only status, its counter and the last command
// - Channel read needs exactly one channel bit
// - Word is 29 bits, fixed header positions
// - Set codes pick control, gain, offset, input data
`timescale 1ns/1ns
`default_nettype none
module scwd_decoder (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire scwd_pkg::scwd_link_t link,
    output logic sdo,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [21:0] cmp_status,
    input wire logic [21:0] alarm_status,
    output scwd_pkg::scwd_wr_t wr_req,
    output logic wr_valid,
    output logic [21:0] sys_cfg
);
    import scwd_pkg::*;

    // True when exactly one channel bit is set
    function automatic logic onehot4(input logic [3:0] c);
        onehot4 = (c == 4'h1) || (c == 4'h2) || (c == 4'h4) || (c == 4'h8);
    endfunction

    // Bank index of a one-hot channel and a register set
    function automatic logic [3:0] bank_idx(input logic [3:0] c, input logic [1:0] r);
        logic [1:0] n;
        n = c[3] ? 2'h3 : c[2] ? 2'h2 : c[1] ? 2'h1 : 2'h0;
        bank_idx = {n, r};
    endfunction

    scwd_link_t s_link;
    scwd_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .d(link),
        .q(s_link)
    );

    // Link-side state
    scwd_state_t state_ff, nxt_state;
    logic sclk_d_ff, nxt_sclk_d;
    logic sync_d_ff, nxt_sync_d;
    logic [28:0] shift_ff, nxt_shift;
    logic [28:0] rb_ff, nxt_rb;
    logic [5:0] cnt_ff, nxt_cnt;
    logic sdo_ff, nxt_sdo;
    logic [21:0] sys_cfg_ff, nxt_sys_cfg;
    logic [21:0] bank_ff [16];
    logic [21:0] nxt_bank [16];
    scwd_wr_t wr_ff, nxt_wr;
    logic wr_valid_ff, nxt_wr_valid;
    scwd_cls_t cls_ff, nxt_cls;
    logic [28:0] last_cmd_ff, nxt_last_cmd;
    logic [7:0] rsvd_cnt_ff, nxt_rsvd_cnt;
    logic [7:0] nop_cnt_ff, nxt_nop_cnt;
    logic [7:0] len_cnt_ff, nxt_len_cnt;

    // Bus-side state
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic en_ff, nxt_en;
    logic cnt_clr;

    // Decode fields of the received word
    logic rd;
    logic [3:0] ch;
    logic [1:0] rs;
    logic [21:0] dat;
    logic sclk_rise, frame_start, frame_end;
    logic [3:0] ch_hit;
    scwd_cls_t cls;
    logic [21:0] rb_val;

    assign rd = shift_ff[RW_BIT];
    assign ch = shift_ff[CH_HI:CH_LO];
    assign rs = shift_ff[RS_HI:RS_LO];
    assign dat = shift_ff[DATA_W-1:0];
    assign sclk_rise = s_link.sclk & ~sclk_d_ff;
    assign frame_start = sync_d_ff & ~s_link.sync_n;
    assign frame_end = ~sync_d_ff & s_link.sync_n & (state_ff == ST_FRAME);

    // Classify the word and pick the readback value
    always_comb begin
        cls = CLS_RSVD;
        rb_val = DATA_ZERO;
        if (!en_ff) begin
            cls = CLS_OFF;
        end else if (cnt_ff != CMD_BITS) begin
            cls = CLS_LEN_ERR;
        end else if (!rd && ch == 4'h0) begin
            if (rs == RS_CTRL) begin
                cls = CLS_SYS_WR;
            end else if (rs == RS_DATA && dat == DATA_ONES) begin
                cls = CLS_NOP;
            end
        end else if (!rd) begin
            cls = CLS_CH_WR;
        end else if (ch == 4'h0) begin
            if (dat == DATA_ZERO && rs != RS_OFFS) begin
                cls = CLS_RD;
                case (rs)
                    RS_CTRL: rb_val = sys_cfg_ff;
                    RS_GAIN: rb_val = cmp_status;
                    default: rb_val = alarm_status;
                endcase
            end
        end else if (onehot4(ch)) begin
            cls = CLS_RD;
            rb_val = bank_ff[bank_idx(ch, rs)];
        end
    end

    // Per-channel write enables
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            assign ch_hit[gi] = frame_end && (cls == CLS_CH_WR) && ch[gi];
        end
    endgenerate

    // Next state of the link side
    always_comb begin
        nxt_state = state_ff;
        nxt_sclk_d = s_link.sclk;
        nxt_sync_d = s_link.sync_n;
        nxt_shift = shift_ff;
        nxt_rb = rb_ff;
        nxt_cnt = cnt_ff;
        nxt_sdo = sdo_ff;
        nxt_sys_cfg = sys_cfg_ff;
        nxt_bank = bank_ff;
        nxt_wr = wr_ff;
        nxt_wr_valid = 1'b0;
        nxt_cls = cls_ff;
        nxt_last_cmd = last_cmd_ff;
        nxt_rsvd_cnt = cnt_clr ? 8'h00 : rsvd_cnt_ff;
        nxt_nop_cnt = cnt_clr ? 8'h00 : nop_cnt_ff;
        nxt_len_cnt = cnt_clr ? 8'h00 : len_cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (frame_start) begin
                    nxt_state = ST_FRAME;
                    nxt_cnt = 6'h00;
                    nxt_sdo = rb_ff[CMD_W-1];
                end
            end
            ST_FRAME: begin
                if (frame_end) begin
                    nxt_state = ST_IDLE;
                    nxt_cls = cls;
                    nxt_last_cmd = shift_ff;
                    // Counters: a same-cycle clear applies first, then the event counts one
                    if (cls == CLS_RSVD) begin
                        nxt_rsvd_cnt = nxt_rsvd_cnt + 8'h01;
                    end
                    if (cls == CLS_NOP) begin
                        nxt_nop_cnt = nxt_nop_cnt + 8'h01;
                    end
                    if (cls == CLS_LEN_ERR) begin
                        nxt_len_cnt = nxt_len_cnt + 8'h01;
                    end
                    if (cls == CLS_SYS_WR) begin
                        nxt_sys_cfg = dat;
                    end
                    if (cls == CLS_RD) begin
                        nxt_rb = {shift_ff[CMD_W-1:DATA_W], rb_val};
                    end
                    if (cls == CLS_CH_WR) begin
                        nxt_wr = '{ch: ch, rs: rs, data: dat};
                        nxt_wr_valid = 1'b1;
                    end
                    for (int c = 0; c < NCH; c++) begin
                        if (ch_hit[c]) begin
                            nxt_bank[bank_idx(4'h1 << c, rs)] = dat;
                        end
                    end
                end else if (sclk_rise) begin
                    nxt_shift = {shift_ff[CMD_W-2:0], s_link.sdi};
                    nxt_rb = {rb_ff[CMD_W-2:0], 1'b0};
                    nxt_sdo = rb_ff[CMD_W-2];
                    if (cnt_ff != CNT_MAX) begin
                        nxt_cnt = cnt_ff + 6'h01;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Link-side registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            sclk_d_ff <= 1'b1;
            sync_d_ff <= 1'b1;
            shift_ff <= '0;
            rb_ff <= '0;
            cnt_ff <= 6'h00;
            sdo_ff <= 1'b0;
            sys_cfg_ff <= SYSCFG_RST;
            for (int k = 0; k < 16; k++) begin
                bank_ff[k] <= BANK_RST;
            end
            wr_ff <= '0;
            wr_valid_ff <= 1'b0;
            cls_ff <= CLS_NONE;
            last_cmd_ff <= '0;
            rsvd_cnt_ff <= 8'h00;
            nop_cnt_ff <= 8'h00;
            len_cnt_ff <= 8'h00;
        end else if (ce) begin
            state_ff <= nxt_state;
            sclk_d_ff <= nxt_sclk_d;
            sync_d_ff <= nxt_sync_d;
            shift_ff <= nxt_shift;
            rb_ff <= nxt_rb;
            cnt_ff <= nxt_cnt;
            sdo_ff <= nxt_sdo;
            sys_cfg_ff <= nxt_sys_cfg;
            bank_ff <= nxt_bank;
            wr_ff <= nxt_wr;
            wr_valid_ff <= nxt_wr_valid;
            cls_ff <= nxt_cls;
            last_cmd_ff <= nxt_last_cmd;
            rsvd_cnt_ff <= nxt_rsvd_cnt;
            nop_cnt_ff <= nxt_nop_cnt;
            len_cnt_ff <= nxt_len_cnt;
        end
    end

    // Avalon slave: one wait cycle, write acts when waitrequest is low
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign cnt_clr = ce & ack_ff & avs_write & (avs_address == OFF_CTRL) & avs_writedata[CTRL_CLR_BIT];

    always_comb begin
        nxt_ack = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        nxt_en = en_ff;
        if (avs_read && !ack_ff) begin
            case (avs_address)
                OFF_CTRL: nxt_rdata = {31'h0000_0000, en_ff};
                OFF_STAT: nxt_rdata = {rsvd_cnt_ff, nop_cnt_ff, len_cnt_ff, 3'h0,
                                       state_ff == ST_FRAME, cls_ff};
                OFF_SYSCFG: nxt_rdata = {10'h000, sys_cfg_ff};
                OFF_LASTCMD: nxt_rdata = {3'h0, last_cmd_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (ack_ff && avs_write && avs_address == OFF_CTRL) begin
            nxt_en = avs_writedata[CTRL_EN_BIT];
        end
    end

    // Bus-side registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            en_ff <= CTRL_EN_RST;
        end else if (ce) begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            en_ff <= nxt_en;
        end
    end

    assign avs_readdata = rdata_ff;
    assign sdo = sdo_ff;
    assign wr_req = wr_ff;
    assign wr_valid = wr_valid_ff;
    assign sys_cfg = sys_cfg_ff;
endmodule
`default_nettype wire

// [sim/scwd_asserts.sv]
// Purpose: Bus, link and update timing checks for the decoder
// Assumes: ce held high
// Notes: Bound to every decoder instance
`timescale 1ns/1ns
`default_nettype none
module scwd_asserts (
    input wire logic ref_clk,
    input wire logic srst,
    input wire scwd_pkg::scwd_link_t link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire scwd_pkg::scwd_wr_t wr_req,
    input wire logic wr_valid,
    input wire logic [21:0] sys_cfg
);
    import scwd_pkg::*;
    logic sq_ff, nxt_sq, late;
    logic [3:0] age_ff, nxt_age;
    // Cycles since the frame pin rose, saturating
    always_comb begin
        nxt_sq = srst | link.sync_n;
        nxt_age = age_ff + {3'h0, age_ff != 4'hf};
        if (srst) begin
            nxt_age = 4'hf;
        end else if (link.sync_n && !sq_ff) begin
            nxt_age = 4'h0;
        end
    end
    always_ff @(posedge ref_clk) begin
        sq_ff <= nxt_sq;
        age_ff <= nxt_age;
    end
    // Window in which frame effects may land
    assign late = link.sync_n && age_ff >= 4'h2 && age_ff <= 4'h9;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    a_one_wait: assert property (s_req |=> s_ack)
        else $error("no answer after one wait");
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> s_req)
        else $error("answered at once");
    a_wr_pulse: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse too long");
    a_req_moves: assert property ($changed(wr_req) |-> wr_valid)
        else $error("request moved alone");
    a_wr_chans: assert property (wr_valid |-> wr_req.ch != 4'h0)
        else $error("write without channel");
    a_cfg_alone: assert property ($changed(sys_cfg) |-> !wr_valid)
        else $error("config write pulsed");
    a_wr_window: assert property (wr_valid |-> late)
        else $error("write outside frame end");
    a_cfg_window: assert property ($changed(sys_cfg) |-> late)
        else $error("config outside frame end");
    a_cfg_read: assert property (s_ack ##0 avs_read && avs_address == OFF_SYSCFG |->
        avs_readdata == {10'h000, sys_cfg}) else $error("config readback wrong");
    a_hole_zero: assert property (s_ack ##0 avs_read && avs_address[1:0] != 2'h0 |->
        avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
bind scwd_decoder scwd_asserts chk_i (.ref_clk, .srst, .link, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .wr_req, .wr_valid, .sys_cfg);
`default_nettype wire

// [sim/scwd_host.sv]
// Purpose: Host controller model on the serial command port
// Assumes: sclk parks high; sdi moves on falling sclk
// Notes: Readback bit taken just before each rising sclk
`timescale 1ns/1ns
`default_nettype none
module scwd_host (
    output var scwd_pkg::scwd_link_t link,
    input wire logic sdo
);
    import scwd_pkg::*;
    // Idle link
    initial begin
        link = 3'b111;
    end
    // Send n bits MSB first, collect readback
    task automatic send(input logic [28:0] w, input int n, output logic [28:0] rb);
        int i;
        rb = 29'h0000_0000;
        link.sync_n = 1'b0;
        #63;
        for (i = 28; i > 28 - n; i--) begin
            link.sclk = 1'b0;
            link.sdi = w[i];
            #62;
            rb[i] = sdo;
            link.sclk = 1'b1;
            #63;
        end
        link.sync_n = 1'b1;
        link.sdi = ~link.sdi; // Released line shows no stale bit
        #250;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the command word decoder
// Assumes: ce tied high; status inputs held steady
// Notes: Bus tasks wait for waitrequest low
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import scwd_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, sdo, wr_valid;
    logic [21:0] cmp_status = 22'h15_a0c3;
    logic [21:0] alarm_status = 22'h2b_0f71;
    logic [21:0] sys_cfg, v;
    logic [21:0] bank [4][4];
    logic [28:0] w, rb, exp_rb;
    logic [28:0] bad [5] = '{29'h0040_0000, 29'h0080_0000, 29'h00ff_fffe, 29'h1080_0000, 29'h1300_0000};
    scwd_link_t link;
    scwd_wr_t wr_req, last_wr;
    int err_count = 0;
    int checks_done = 0;
    int n_wr = 0;
    int cyc = 0;
    int c, k;

    always #2 ref_clk = ~ref_clk;

    scwd_decoder dut (.ref_clk, .srst, .ce(1'b1), .link, .sdo, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .cmp_status, .alarm_status, .wr_req,
        .wr_valid, .sys_cfg);
    scwd_host host (.link, .sdo);

    // Count write pulses, keep last request, cut hangs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (wr_valid === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wr <= wr_req;
        end
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon cycle; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= we;
        avs_read <= !we;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task end_sim;
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        bank = '{default: BANK_RST};
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        bus(1'b0, OFF_CTRL, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        chk(sys_cfg, SYSCFG_RST);
        bus(1'b1, 4'h2, 32'hffff_ffff, rd);
        bus(1'b0, 4'h2, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        host.send(29'h002a_5a5a, 29, rb);
        chk(sys_cfg, 22'h2a_5a5a);
        chk(n_wr, 0);
        // Every channel combination, each with the register set given by its low two bits
        for (k = 1; k < 16; k++) begin
            v = 22'(k * 32'h0001_1111);
            host.send({1'b0, k[3:0], k[1:0], v}, 29, rb);
            chk(n_wr, k);
            chk(last_wr, {k[3:0], k[1:0], v});
            for (c = 0; c < 4; c++) begin
                if (k[c]) begin
                    bank[c][k[1:0]] = v;
                end
            end
        end
        // Chained reads: each frame returns the one before
        for (k = 0; k < 19; k++) begin
            w = {1'b1, 4'(k < 16 ? 1 << (k / 4) : 0), 2'(k < 16 ? k : k - 16 + k / 18), DATA_ZERO};
            v = k < 16 ? bank[k / 4][k % 4] : k == 16 ? 22'h2a_5a5a : k == 17 ? cmp_status : alarm_status;
            host.send(w, 29, rb);
            if (k > 0) begin
                chk(rb, exp_rb);
            end
            exp_rb = {w[28:22], v};
        end
        host.send(29'h00ff_ffff, 29, rb);
        chk(rb, exp_rb);
        chk(n_wr, 15);
        chk(sys_cfg, 22'h2a_5a5a);
        // Refused frames: reserved, short, decoder off
        for (k = 0; k < 5; k++) begin
            host.send(bad[k], 29, rb);
        end
        host.send(29'h0015_0f0f, 28, rb);
        chk(rb, 29'h0000_0000);
        chk(sys_cfg, 22'h2a_5a5a);
        bus(1'b1, OFF_CTRL, 32'h0000_0000, rd);
        host.send(29'h0015_0f0f, 29, rb);
        chk(sys_cfg, 22'h2a_5a5a);
        chk(n_wr, 15);
        bus(1'b0, OFF_STAT, 32'h0000_0000, rd);
        chk({rd[31:8], rd[4:0]}, {24'h05_0101, 5'h07});
        bus(1'b0, OFF_SYSCFG, 32'h0000_0000, rd);
        chk(rd, 32'h002a_5a5a);
        bus(1'b0, OFF_LASTCMD, 32'h0000_0000, rd);
        chk(rd, 32'h0015_0f0f);
        bus(1'b1, OFF_CTRL, 32'h0000_0003, rd);
        bus(1'b0, OFF_STAT, 32'h0000_0000, rd);
        chk(rd[31:8], 24'h00_0000);
        end_sim();
    end
endmodule
`default_nettype wire
